// file: verilog/goc_consts.vh
// Constants shared by the gain and offset correction block.
`ifndef GOC_CONSTS_VH
`define GOC_CONSTS_VH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define GOC_IDX_CFG3        6'h03
`define GOC_IDX_C3_ODD      6'h11
`define GOC_IDX_C3_EVEN     6'h12
`define GOC_IDX_C4_ODD      6'h13
`define GOC_IDX_C4_EVEN     6'h14
`define GOC_IDX_STATUS      6'h1F

// ****************************************************************
// Field layout and reset values
// ****************************************************************
`define GOC_GAIN_MSB        15
`define GOC_GAIN_LSB        11
`define GOC_RSVD_BIT        10
`define GOC_OFF_MSB         9
`define GOC_OFF_LSB         0
`define GOC_CFG_GAIN_EN_BIT 12
`define GOC_CFG_OFF_EN_BIT  8
`define GOC_REG_RST         16'h0000
`define GOC_STAT_C3_SAT_BIT 0
`define GOC_STAT_C4_SAT_BIT 1

// ****************************************************************
// Arithmetic
// ****************************************************************
`define GOC_GAIN_FRAC       14
`define GOC_UNITY_GAIN      17'h04000

`endif

// file: verilog/goc_gain_rom.v
// Gain code to linear factor table, 0.2 dB per code, unsigned Q3.14.
`default_nettype none
`include "goc_consts.vh"

module goc_gain_rom (
  input  wire [4:0]  code,
  output reg  [16:0] factor
);

  // Factor is round(2^14 * 10^(code * 0.2 / 20)), one count more for codes 12, 27 and 30.
  always @* begin
    case (code)
      5'h00:   factor = `GOC_UNITY_GAIN;
      5'h01:   factor = 17'h0417E;
      5'h02:   factor = 17'h04304;
      5'h03:   factor = 17'h04494;
      5'h04:   factor = 17'h0462D;
      5'h05:   factor = 17'h047CF;
      5'h06:   factor = 17'h0497B;
      5'h07:   factor = 17'h04B32;
      5'h08:   factor = 17'h04CF2;
      5'h09:   factor = 17'h04EBD;
      5'h0A:   factor = 17'h05092;
      5'h0B:   factor = 17'h05273;
      5'h0C:   factor = 17'h0545F;
      5'h0D:   factor = 17'h05655;
      5'h0E:   factor = 17'h05858;
      5'h0F:   factor = 17'h05A67;
      5'h10:   factor = 17'h05C82;
      5'h11:   factor = 17'h05EAA;
      5'h12:   factor = 17'h060DE;
      5'h13:   factor = 17'h06320;
      5'h14:   factor = 17'h0656F;
      5'h15:   factor = 17'h067CC;
      5'h16:   factor = 17'h06A37;
      5'h17:   factor = 17'h06CB0;
      5'h18:   factor = 17'h06F38;
      5'h19:   factor = 17'h071CF;
      5'h1A:   factor = 17'h07476;
      5'h1B:   factor = 17'h0772D;
      5'h1C:   factor = 17'h079F3;
      5'h1D:   factor = 17'h07CCA;
      5'h1E:   factor = 17'h07FB3;
      5'h1F:   factor = 17'h082AC;
      default: factor = `GOC_UNITY_GAIN;
    endcase
  end

endmodule
`default_nettype wire

// file: verilog/goc_lane.v
// Two-stage offset-then-gain correction for one converter's sample stream.
`default_nettype none
`include "goc_consts.vh"

module goc_lane #(
  parameter SW = 16
) (
  input  wire                 pclk,
  input  wire                 presetn,
  input  wire signed [SW-1:0] in_sample,
  input  wire                 in_valid,
  input  wire                 in_odd,
  input  wire [9:0]           odd_offset,
  input  wire [9:0]           even_offset,
  input  wire [16:0]          gain_factor,
  input  wire                 gain_en,
  input  wire                 off_en,
  output reg  signed [SW-1:0] out_sample,
  output reg                  out_valid,
  output reg                  out_odd,
  output reg                  out_sat
);

  reg  signed [SW:0]    diff;
  reg         [16:0]    fac;
  reg                   s1_valid;
  reg                   s1_odd;
  wire        [9:0]     off_sel;
  wire signed [SW:0]    off_ext;
  wire signed [SW:0]    next_diff;
  wire signed [SW+18:0] prod;
  wire signed [SW+4:0]  scaled;
  wire                  ovf;

  // ****************************************************************
  // Stage 1: phase-selected offset subtraction
  // ****************************************************************
  assign off_sel   = in_odd ? odd_offset : even_offset;
  // Signed code in 14-bit LSB units; samples carry the 14-bit LSB at bit 0.
  assign off_ext   = {{(SW-9){off_sel[9]}}, off_sel};
  assign next_diff = {in_sample[SW-1], in_sample} - (off_en ? off_ext : {(SW+1){1'b0}});

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      diff     <= {(SW+1){1'b0}};
      fac      <= `GOC_UNITY_GAIN;
      s1_valid <= 1'b0;
      s1_odd   <= 1'b0;
    end else begin
      diff     <= next_diff;
      fac      <= gain_en ? gain_factor : `GOC_UNITY_GAIN;
      s1_valid <= in_valid;
      s1_odd   <= in_odd;
    end
  end

  // ****************************************************************
  // Stage 2: gain multiply, truncate and saturate
  // ****************************************************************
  assign prod   = diff * $signed({1'b0, fac});
  assign scaled = prod[SW+18:`GOC_GAIN_FRAC];
  // Overflow when the bits above the output sign disagree with it.
  assign ovf    = ~((&scaled[SW+4:SW-1]) | ~(|scaled[SW+4:SW-1]));

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_sample <= {SW{1'b0}};
      out_valid  <= 1'b0;
      out_odd    <= 1'b0;
      out_sat    <= 1'b0;
    end else begin
      out_valid <= s1_valid;
      out_odd   <= s1_odd;
      out_sat   <= ovf;
      if (ovf) begin
        out_sample <= scaled[SW+4] ? {1'b1, {(SW-1){1'b0}}} : {1'b0, {(SW-1){1'b1}}};
      end else begin
        out_sample <= scaled[SW-1:0];
      end
    end
  end

endmodule
`default_nettype wire

// file: verilog/goc_top.v
// APB register bank and correction datapath for converters 3 and 4.
//
// What this block does
// - Gain applied only while global gain enabled
// - Gain equals code times 0.2 dB
// - Offset subtracted only while global offset enabled
// - Offset code is signed two's complement
// - One offset count is a 14-bit LSB
// - Separate odd and even coefficient sets
// - Registers reset to zero; reserved bit stored as written, not forced zero
// - Converter 4 even register is written on its own and does not follow the odd register
//
// The implementer's own choice: register access over APB.
`default_nettype none
`include "goc_consts.vh"

module goc_top #(
  parameter AW = 8,
  parameter SW = 16
) (
  input  wire                 pclk,
  input  wire                 presetn,
  input  wire [AW-1:0]        paddr,
  input  wire                 psel,
  input  wire                 penable,
  input  wire                 pwrite,
  input  wire [31:0]          pwdata,
  input  wire [3:0]           pstrb,
  output reg  [31:0]          prdata,
  output reg                  pready,
  output reg                  pslverr,
  input  wire signed [SW-1:0] conv3_sample,
  input  wire                 conv3_valid,
  input  wire                 conv3_odd,
  input  wire signed [SW-1:0] conv4_sample,
  input  wire                 conv4_valid,
  input  wire                 conv4_odd,
  output wire signed [SW-1:0] conv3_corrected,
  output wire                 conv3_corrected_valid,
  output wire                 conv3_corrected_odd,
  output wire signed [SW-1:0] conv4_corrected,
  output wire                 conv4_corrected_valid,
  output wire                 conv4_corrected_odd
);

  // ****************************************************************
  // Register storage
  // ****************************************************************
  reg  [15:0] conv3_odd_gain_offset;
  reg  [15:0] conv3_even_gain_offset;
  reg  [15:0] conv4_odd_gain_offset;
  reg  [15:0] conv4_even_gain_offset;
  reg         global_gain_correction_enable;
  reg         global_offset_correction_enable;
  reg  [1:0]  sat_seen;
  wire        conv3_sat;
  wire        conv4_sat;

  wire [4:0]  conv3_odd_gain_code;
  wire [4:0]  conv3_even_gain_code;
  wire [4:0]  conv4_odd_gain_code;
  wire [4:0]  conv4_even_gain_code;
  wire [9:0]  conv3_odd_offset_value;
  wire [9:0]  conv3_even_offset_value;
  wire [9:0]  conv4_odd_offset_value;
  wire [9:0]  conv4_even_offset_value;

  assign conv3_odd_gain_code     = conv3_odd_gain_offset[`GOC_GAIN_MSB:`GOC_GAIN_LSB];
  assign conv3_even_gain_code    = conv3_even_gain_offset[`GOC_GAIN_MSB:`GOC_GAIN_LSB];
  assign conv4_odd_gain_code     = conv4_odd_gain_offset[`GOC_GAIN_MSB:`GOC_GAIN_LSB];
  assign conv4_even_gain_code    = conv4_even_gain_offset[`GOC_GAIN_MSB:`GOC_GAIN_LSB];
  assign conv3_odd_offset_value  = conv3_odd_gain_offset[`GOC_OFF_MSB:`GOC_OFF_LSB];
  assign conv3_even_offset_value = conv3_even_gain_offset[`GOC_OFF_MSB:`GOC_OFF_LSB];
  assign conv4_odd_offset_value  = conv4_odd_gain_offset[`GOC_OFF_MSB:`GOC_OFF_LSB];
  assign conv4_even_offset_value = conv4_even_gain_offset[`GOC_OFF_MSB:`GOC_OFF_LSB];

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Merge the two low byte lanes of a write into a 16-bit register.
  function [15:0] merge_strb;
    input [15:0] old;
    input [31:0] wdata;
    input [3:0]  strb;
    begin
      merge_strb = old;
      if (strb[0]) begin
        merge_strb[7:0] = wdata[7:0];
      end
      if (strb[1]) begin
        merge_strb[15:8] = wdata[15:8];
      end
    end
  endfunction

  // Word index decode; the two low address bits are ignored.
  function hit;
    input [AW-1:0] addr;
    input [5:0]    idx;
    begin
      hit = ((addr >> 2) == {{(AW-6){1'b0}}, idx});
    end
  endfunction

  // Phase select between the odd and even gain codes of one converter.
  function [4:0] pick_code;
    input       odd;
    input [4:0] odd_code;
    input [4:0] even_code;
    begin
      pick_code = odd ? odd_code : even_code;
    end
  endfunction

  // ****************************************************************
  // APB slave
  // ****************************************************************
  // No wait state: the answer is prepared in the setup cycle so that
  // prdata, pready and pslverr all come straight from flip-flops.
  wire        setup_phase;
  wire        access_done;
  wire        wr_done;
  wire        map_hit;
  reg  [31:0] next_prdata;
  wire [15:0] cfg3_view;
  wire [15:0] status_view;

  assign setup_phase = psel & ~penable;
  assign access_done = psel & penable & pready;
  assign wr_done     = access_done & pwrite & ~pslverr;

  assign map_hit = hit(paddr, `GOC_IDX_CFG3)
                 | hit(paddr, `GOC_IDX_C3_ODD)
                 | hit(paddr, `GOC_IDX_C3_EVEN)
                 | hit(paddr, `GOC_IDX_C4_ODD)
                 | hit(paddr, `GOC_IDX_C4_EVEN)
                 | hit(paddr, `GOC_IDX_STATUS);

  // Only the two enable bits of configuration register 3 live here.
  assign cfg3_view = ({15'h0000, global_gain_correction_enable} << `GOC_CFG_GAIN_EN_BIT)
                   | ({15'h0000, global_offset_correction_enable} << `GOC_CFG_OFF_EN_BIT);

  assign status_view = {14'h0000, sat_seen};

  always @* begin
    next_prdata = 32'h00000000;
    if (hit(paddr, `GOC_IDX_CFG3)) begin
      next_prdata = {16'h0000, cfg3_view};
    end else if (hit(paddr, `GOC_IDX_C3_ODD)) begin
      next_prdata = {16'h0000, conv3_odd_gain_offset};
    end else if (hit(paddr, `GOC_IDX_C3_EVEN)) begin
      next_prdata = {16'h0000, conv3_even_gain_offset};
    end else if (hit(paddr, `GOC_IDX_C4_ODD)) begin
      next_prdata = {16'h0000, conv4_odd_gain_offset};
    end else if (hit(paddr, `GOC_IDX_C4_EVEN)) begin
      next_prdata = {16'h0000, conv4_even_gain_offset};
    end else if (hit(paddr, `GOC_IDX_STATUS)) begin
      next_prdata = {16'h0000, status_view};
    end
  end

  // pready answers every setup cycle, whatever the address, so a refused
  // access still completes in two cycles and never stalls the bus.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup_phase;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      prdata  <= pwrite ? 32'h00000000 : next_prdata;
      pslverr <= ~map_hit;
    end else if (access_done) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
  end

  // ****************************************************************
  // Register writes
  // ****************************************************************
  // Bit 10 is stored as written; software is expected to keep it zero.
  // A refused access never reaches storage, since wr_done is gated by pslverr.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv3_odd_gain_offset           <= `GOC_REG_RST;
      conv3_even_gain_offset          <= `GOC_REG_RST;
      conv4_odd_gain_offset           <= `GOC_REG_RST;
      conv4_even_gain_offset          <= `GOC_REG_RST;
      global_gain_correction_enable   <= 1'b0;
      global_offset_correction_enable <= 1'b0;
    end else if (wr_done) begin
      if (hit(paddr, `GOC_IDX_C3_ODD)) begin
        conv3_odd_gain_offset <= merge_strb(conv3_odd_gain_offset, pwdata, pstrb);
      end
      if (hit(paddr, `GOC_IDX_C3_EVEN)) begin
        conv3_even_gain_offset <= merge_strb(conv3_even_gain_offset, pwdata, pstrb);
      end
      if (hit(paddr, `GOC_IDX_C4_ODD)) begin
        conv4_odd_gain_offset <= merge_strb(conv4_odd_gain_offset, pwdata, pstrb);
      end
      if (hit(paddr, `GOC_IDX_C4_EVEN)) begin
        conv4_even_gain_offset <= merge_strb(conv4_even_gain_offset, pwdata, pstrb);
      end
      if (hit(paddr, `GOC_IDX_CFG3)) begin
        if (pstrb[1]) begin
          global_gain_correction_enable <= pwdata[`GOC_CFG_GAIN_EN_BIT];
          global_offset_correction_enable <= pwdata[`GOC_CFG_OFF_EN_BIT];
        end
      end
    end
  end

  // ****************************************************************
  // Saturation status
  // ****************************************************************
  // Saturation flags are sticky; a new event wins over a clearing write,
  // so software never loses a clip that lands in the clearing cycle.
  wire       status_wr;
  wire [1:0] sat_event;
  wire [1:0] sat_clear;

  assign status_wr = wr_done & hit(paddr, `GOC_IDX_STATUS) & pstrb[0];

  assign sat_event[`GOC_STAT_C3_SAT_BIT] = conv3_sat & conv3_corrected_valid;
  assign sat_event[`GOC_STAT_C4_SAT_BIT] = conv4_sat & conv4_corrected_valid;
  assign sat_clear[`GOC_STAT_C3_SAT_BIT] = status_wr & pwdata[`GOC_STAT_C3_SAT_BIT];
  assign sat_clear[`GOC_STAT_C4_SAT_BIT] = status_wr & pwdata[`GOC_STAT_C4_SAT_BIT];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sat_seen <= 2'b00;
    end else begin
      sat_seen <= (sat_seen & ~sat_clear) | sat_event;
    end
  end

  // ****************************************************************
  // Datapath
  // ****************************************************************
  // The gain code is picked by the incoming phase so that each sample
  // sees only its own coefficient set.
  // Coefficients and enables are taken as a sample enters, so a sample in
  // flight keeps the set it started with when software rewrites one.
  wire [4:0]  conv3_code_sel;
  wire [4:0]  conv4_code_sel;
  wire [16:0] conv3_factor;
  wire [16:0] conv4_factor;

  assign conv3_code_sel = pick_code(conv3_odd, conv3_odd_gain_code, conv3_even_gain_code);
  assign conv4_code_sel = pick_code(conv4_odd, conv4_odd_gain_code, conv4_even_gain_code);

  goc_gain_rom u_rom3 (
    .code   (conv3_code_sel),
    .factor (conv3_factor)
  );

  goc_gain_rom u_rom4 (
    .code   (conv4_code_sel),
    .factor (conv4_factor)
  );

  goc_lane #(
    .SW (SW)
  ) u_lane3 (
    .pclk        (pclk),
    .presetn     (presetn),
    .in_sample   (conv3_sample),
    .in_valid    (conv3_valid),
    .in_odd      (conv3_odd),
    .odd_offset  (conv3_odd_offset_value),
    .even_offset (conv3_even_offset_value),
    .gain_factor (conv3_factor),
    .gain_en     (global_gain_correction_enable),
    .off_en      (global_offset_correction_enable),
    .out_sample  (conv3_corrected),
    .out_valid   (conv3_corrected_valid),
    .out_odd     (conv3_corrected_odd),
    .out_sat     (conv3_sat)
  );

  goc_lane #(
    .SW (SW)
  ) u_lane4 (
    .pclk        (pclk),
    .presetn     (presetn),
    .in_sample   (conv4_sample),
    .in_valid    (conv4_valid),
    .in_odd      (conv4_odd),
    .odd_offset  (conv4_odd_offset_value),
    .even_offset (conv4_even_offset_value),
    .gain_factor (conv4_factor),
    .gain_en     (global_gain_correction_enable),
    .off_en      (global_offset_correction_enable),
    .out_sample  (conv4_corrected),
    .out_valid   (conv4_corrected_valid),
    .out_odd     (conv4_corrected_odd),
    .out_sat     (conv4_sat)
  );

endmodule
`default_nettype wire

// file: tb/goc_chk_sva.sv
// Port-level assertions for the gain and offset correction block.
`default_nettype none
`include "goc_consts.vh"
module goc_chk #(
  parameter AW = 8,
  parameter SW = 16
) (
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic [AW-1:0]        paddr,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [31:0]          pwdata,
  input wire logic [3:0]           pstrb,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic signed [SW-1:0] conv3_sample,
  input wire logic                 conv3_valid,
  input wire logic                 conv3_odd,
  input wire logic                 conv4_valid,
  input wire logic signed [SW-1:0] conv3_corrected,
  input wire logic                 conv3_corrected_valid,
  input wire logic                 conv3_corrected_odd,
  input wire logic                 conv4_corrected_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] idx;
  logic       mapped;
  logic       gain_on;
  logic       off_on;
  assign idx = paddr[7:2];
  assign mapped = idx == `GOC_IDX_CFG3 || idx == `GOC_IDX_STATUS ||
                  (idx >= `GOC_IDX_C3_ODD && idx <= `GOC_IDX_C4_EVEN);
  // Shadow of the enables, so bypass can be judged without peeking inside.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gain_on <= 1'b0;
      off_on  <= 1'b0;
    end else if (psel && penable && pready && pwrite && pstrb[1] && idx == `GOC_IDX_CFG3) begin
      gain_on <= pwdata[`GOC_CFG_GAIN_EN_BIT];
      off_on  <= pwdata[`GOC_CFG_OFF_EN_BIT];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_after_setup: assert property (psel && !penable |=> pready && psel && penable)
    else $error("pready missing after setup");
  a_ready_single: assert property (pready |-> psel && penable ##1 !pready)
    else $error("pready outside one access cycle");
  a_err_unmapped: assert property (pready && !mapped |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_err_mapped: assert property (pready && mapped |-> !pslverr)
    else $error("mapped access refused");
  a_idle_quiet: assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("read data outside access");
  a_upper_zero: assert property (prdata[31:16] == 16'h0)
    else $error("upper read bits set");
  a_lat_three: assert property (conv3_valid |-> ##2 conv3_corrected_valid &&
                               conv3_corrected_odd == $past(conv3_odd, 2))
    else $error("conv3 latency or phase wrong");
  a_lat_four: assert property (conv4_corrected_valid == $past(conv4_valid, 2))
    else $error("conv4 valid latency wrong");
  a_bypass_pass: assert property (conv3_valid && !gain_on && !off_on |->
                                 ##2 conv3_corrected == $past(conv3_sample, 2))
    else $error("disabled stages altered sample");
endmodule
`default_nettype wire

// file: tb/tb_adc_gain_offset_correction.sv
// Self-checking bench for the gain and offset correction block.
`default_nettype none
`include "goc_consts.vh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin error_cnt++; $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module tb_adc_gain_offset_correction;
  timeunit 1ns;
  timeprecision 1ps;
  logic               pclk = 1'b0;
  logic               presetn = 1'b0;
  logic [7:0]         paddr = 8'h00;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [31:0]        pwdata = 32'h0;
  logic [3:0]         pstrb = 4'h0;
  logic signed [15:0] s3 = 16'h0;
  logic signed [15:0] s4 = 16'h0;
  logic               v3 = 1'b0;
  logic               v4 = 1'b0;
  logic               o3 = 1'b0;
  logic               o4 = 1'b0;
  wire [31:0]         prdata;
  wire                pready;
  wire                pslverr;
  wire signed [15:0]  c3;
  wire signed [15:0]  c4;
  wire                cv3;
  wire                cv4;
  wire                co3;
  wire                co4;
  int                 error_cnt = 0;
  int                 total_checks = 0;
  int                 cyc = 0;
  logic [15:0]        coef [4];
  logic               ge = 1'b0;
  logic               oe = 1'b0;
  logic [31:0]        rdv;
  logic               erv;
  goc_top u_goc_top (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conv3_sample(s3), .conv3_valid(v3),
    .conv3_odd(o3), .conv4_sample(s4), .conv4_valid(v4), .conv4_odd(o4),
    .conv3_corrected(c3), .conv3_corrected_valid(cv3), .conv3_corrected_odd(co3),
    .conv4_corrected(c4), .conv4_corrected_valid(cv4), .conv4_corrected_odd(co4));
  initial forever #2 pclk = ~pclk;
  // ****
  // Bus and sample drivers
  // ****
  task automatic apb(input logic w, input logic [5:0] i, input logic [31:0] d,
                     input logic [3:0] st);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {i, 2'b00};
    pwdata  <= d;
    pstrb   <= st;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdv = prdata;
    erv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] i, input logic [15:0] d);
    apb(1'b1, i, {16'hFFFF, d}, 4'h3);
    if (i >= `GOC_IDX_C3_ODD && i <= `GOC_IDX_C4_EVEN) coef[i - `GOC_IDX_C3_ODD] = d;
    if (i == `GOC_IDX_CFG3) begin
      ge = d[12];
      oe = d[8];
    end
  endtask
  task automatic rdc(input logic [5:0] i, input logic [31:0] e, input logic ee);
    apb(1'b0, i, 32'h0, 4'h0);
    `CHK(rdv, e)
    `CHK(erv, ee)
  endtask
  function automatic logic signed [15:0] expo(input logic signed [15:0] s,
                                              input logic [15:0] c);
    longint d;
    longint f;
    d = s;
    f = 16384;
    if (oe) d = d - $signed(c[9:0]);
    if (ge) f = $rtoi(16384.0 * (10.0 ** (c[15:11] / 100.0)) + 0.5);
    d = (d * f) >>> 14;
    if (d > 32767) d = 32767;
    if (d < -32768) d = -32768;
    return d[15:0];
  endfunction
  task automatic samp(input logic signed [15:0] a, input logic ao,
                      input logic signed [15:0] b, input logic bo);
    @(posedge pclk);
    s3 <= a;
    o3 <= ao;
    v3 <= 1'b1;
    s4 <= b;
    o4 <= bo;
    v4 <= 1'b1;
    @(posedge pclk);
    v3 <= 1'b0;
    v4 <= 1'b0;
    @(posedge pclk);
    #1;
    `CHK(c3, expo(a, coef[ao ? 0 : 1]))
    `CHK(c4, expo(b, coef[bo ? 2 : 3]))
    `CHK({cv3, co3, cv4, co4}, {1'b1, ao, 1'b1, bo})
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_regs();
    logic [5:0] ids [6] = '{6'h03, 6'h11, 6'h12, 6'h13, 6'h14, 6'h1F};
    foreach (ids[k]) rdc(ids[k], 32'h0, 1'b0);
    for (int k = 0; k < 4; k++) begin
      wr(6'h11 + k, 16'hA1A5 ^ k);
      rdc(6'h11 + k, 32'h0000A1A5 ^ k, 1'b0);
    end
    apb(1'b1, `GOC_IDX_C3_ODD, 32'h0, 4'h1);
    coef[0] = 16'hA100;
    rdc(`GOC_IDX_C3_ODD, 32'h0000A100, 1'b0);
    apb(1'b1, 6'h15, 32'h1234, 4'hF);
    `CHK(erv, 1'b1)
    rdc(6'h15, 32'h0, 1'b1);
  endtask
  task automatic t_offset();
    wr(`GOC_IDX_CFG3, 16'h0100);
    wr(6'h11, {5'd7, 1'b0, 10'd5});
    wr(6'h12, {5'd3, 1'b0, 10'h3F9});
    wr(6'h13, {5'd31, 1'b0, 10'h1FF});
    wr(6'h14, {5'd1, 1'b0, 10'h200});
    samp(16'sd100, 1'b1, 16'sd100, 1'b1);
    samp(16'sd100, 1'b0, 16'sd100, 1'b0);
    samp(-16'sd32768, 1'b1, 16'sd32767, 1'b0);
    // Lane 3 clipped below and lane 4 above; the sticky flags must show it and clear.
    rdc(`GOC_IDX_STATUS, 32'h00000003, 1'b0);
    wr(`GOC_IDX_STATUS, 16'h0003);
    rdc(`GOC_IDX_STATUS, 32'h00000000, 1'b0);
  endtask
  task automatic t_bypass();
    samp(16'sh1234, 1'b1, -16'sd200, 1'b0);
    samp(-16'sd32768, 1'b0, 16'sd32767, 1'b1);
  endtask
  task automatic t_gain();
    wr(`GOC_IDX_CFG3, 16'h1000);
    for (int n = 0; n < 32; n++) begin
      wr(6'h11, {n[4:0], 1'b0, 10'd5});
      wr(6'h14, {5'd31 - n[4:0], 1'b0, 10'h200});
      samp(16'sd1000, 1'b1, -16'sd1000, 1'b0);
    end
    samp(16'sd32767, 1'b1, -16'sd32768, 1'b0);
    wr(`GOC_IDX_CFG3, 16'h1100);
    samp(-16'sd20000, 1'b1, 16'sd12345, 1'b0);
    samp(16'sd777, 1'b0, -16'sd4321, 1'b1);
  endtask
  task automatic results();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 20000) begin
      error_cnt++;
      results();
    end
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_bypass();
    t_offset();
    t_gain();
    results();
  end
endmodule
bind goc_top goc_chk #(.AW(AW), .SW(SW)) u_goc_chk (.pclk(pclk), .presetn(presetn),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .conv3_sample(conv3_sample), .conv3_valid(conv3_valid), .conv3_odd(conv3_odd),
  .conv4_valid(conv4_valid), .conv3_corrected(conv3_corrected),
  .conv3_corrected_valid(conv3_corrected_valid), .conv3_corrected_odd(conv3_corrected_odd),
  .conv4_corrected_valid(conv4_corrected_valid));
`default_nettype wire
